//--- shared/emu_consts.vh
`ifndef EMU_CONSTS_VH
`define EMU_CONSTS_VH
// Emulation settings register fields
`define EMU_EN_BIT 7
`define EMU_MOD_BIT 6
`define EMU_PWR_HI 5
`define EMU_PWR_LO 4
`define EMU_DEV_BIT 3
`define EMU_FRQ_HI 2
`define EMU_FRQ_LO 0
`define EMU_RESET 8'h00
// Capacitor field of the primary config register
`define CAP_HI 4
`define CAP_LO 0
`define CAP_RESET 5'h00
// Modulation and deviation codes
`define MOD_ASK 1'b0
`define MOD_FSK 1'b1
`define DEV_16K 1'b0
`define DEV_50K 1'b1
// Power step attenuation in dB below maximum
`define PWR_ATT_0 4'h0
`define PWR_ATT_1 4'h3
`define PWR_ATT_2 4'h6
`define PWR_ATT_3 4'ha
// Divide ratios: 8-bit integer, 8-bit fraction (x/256), nearest step
`define DIV_NONE 16'h0000
`define DIV_F1 16'h13b0
`define DIV_F2 16'h1b1a
`define DIV_F3 16'h1860
`define DIV_F4 16'h1a20
`define DIV_F5 16'h1740
`define DIV_F6 16'h1590
`define DIV_F7 16'h1b1f
`endif

//--- test/emc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "emu_consts.vh"
module emc_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic emu_wr,
  input wire logic [7:0] emu_wdata,
  input wire logic cap_wr,
  input wire logic [4:0] cap_wdata,
  input wire logic [7:0] emulation_settings,
  input wire logic [4:0] primary_cap,
  input wire logic emu_active,
  input wire logic mod_fsk,
  input wire logic [3:0] pwr_atten_db,
  input wire logic dev_50k,
  input wire logic [15:0] div_ratio,
  input wire logic [4:0] pa_cap,
  input wire logic freq_select_pin_a,
  input wire logic freq_select_pin_b,
  input wire logic freq_select_pin_c
);
  logic [3:0] att [4] = '{`PWR_ATT_0, `PWR_ATT_1, `PWR_ATT_2, `PWR_ATT_3};
  logic [15:0] dv [8] = '{`DIV_NONE, `DIV_F1, `DIV_F2, `DIV_F3, `DIV_F4, `DIV_F5, `DIV_F6,
    `DIV_F7};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_on; emu_wr && ce && emu_wdata[7] ##1
    ce && !(freq_select_pin_a || freq_select_pin_b || freq_select_pin_c); endsequence
  sequence s_off; emu_wr && ce && !emu_wdata[7] ##1 ce; endsequence
  property p_rd; emu_wr && ce |=> emulation_settings == $past(emu_wdata); endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  property p_act; s_on |=> emu_active; endproperty
  a_act: assert property (p_act) else $error("not active");
  property p_mod; s_on |=> mod_fsk == $past(emu_wdata[6], 2); endproperty
  a_mod: assert property (p_mod) else $error("modulation wrong");
  property p_pwr; s_on |=> pwr_atten_db == att[$past(emu_wdata[5:4], 2)]; endproperty
  a_pwr: assert property (p_pwr) else $error("power wrong");
  property p_dev; s_on |=> dev_50k == $past(emu_wdata[3], 2); endproperty
  a_dev: assert property (p_dev) else $error("deviation wrong");
  property p_div; s_on |=> div_ratio == dv[$past(emu_wdata[2:0], 2)]; endproperty
  a_div: assert property (p_div) else $error("divide ratio wrong");
  property p_cap; cap_wr && ce |=> primary_cap == $past(cap_wdata); endproperty
  a_cap: assert property (p_cap) else $error("cap readback wrong");
  property p_off; s_off |=> !emu_active; endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_man; ce && (freq_select_pin_a || freq_select_pin_b || freq_select_pin_c) |=>
    !emu_active; endproperty
  a_man: assert property (p_man) else $error("active in manual mode");
  property p_ovr; ce && primary_cap != 5'h00 |=> pa_cap == $past(primary_cap); endproperty
  a_ovr: assert property (p_ovr) else $error("written cap not applied");
  property p_frz; !ce |=> $stable(emulation_settings) && $stable(primary_cap) &&
    $stable(pa_cap) && $stable(div_ratio); endproperty
  a_frz: assert property (p_frz) else $error("state moved with enable low");
endmodule // emc_checker
bind emulation_mode_config emc_checker emc_checker_inst (.core_clk, .nrst, .ce, .emu_wr,
  .emu_wdata, .cap_wr, .cap_wdata, .emulation_settings, .primary_cap, .emu_active, .mod_fsk,
  .pwr_atten_db, .dev_50k, .div_ratio, .pa_cap, .freq_select_pin_a, .freq_select_pin_b,
  .freq_select_pin_c);
`default_nettype wire

//--- test/emc_host.sv
`timescale 1ns/1ps
`default_nettype none
module emc_host (
  input wire logic core_clk,
  output logic enable_pin,
  output logic din_pin
);
  initial {enable_pin, din_pin} = 2'b10;
  // First pulse only latches the frequency, so n pulses give n-1
  task automatic cap_pulses(input int n);
    @(negedge core_clk) enable_pin = 1'b0;
    repeat (n) begin
      @(negedge core_clk) din_pin = 1'b1;
      @(negedge core_clk) din_pin = 1'b0;
    end
    @(negedge core_clk) enable_pin = 1'b1;
  endtask
endmodule // emc_host
`default_nettype wire

//--- test/test_emulation_mode_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "emu_consts.vh"
module test_emulation_mode_config;
  logic core_clk = 0, nrst = 0, ce = 1, emu_wr = 0, cap_wr = 0, smod, sdev, en, din, act, fsk;
  logic dev, fpa = 0;
  logic [7:0] d = 8'h00, es;
  logic [4:0] c = 5'h00, pc, pa;
  logic [1:0] spwr, wp = 2'h0;
  logic [3:0] atto;
  logic [15:0] sdiv, dvo;
  logic [22:0] q [$];
  integer seed = 3109;
  int fail_count = 0, check_count = 0;
  logic [3:0] att [4] = '{`PWR_ATT_0, `PWR_ATT_1, `PWR_ATT_2, `PWR_ATT_3};
  logic [15:0] dv [8] = '{`DIV_NONE, `DIV_F1, `DIV_F2, `DIV_F3, `DIV_F4, `DIV_F5, `DIV_F6,
    `DIV_F7};
  always #25 core_clk = ~core_clk;
  emulation_mode_config emulation_mode_config_inst (.core_clk, .nrst, .ce, .emu_wr,
    .emu_wdata(d), .cap_wr, .cap_wdata(c), .enable_pin(en), .din_pin(din),
    .freq_select_pin_a(fpa), .freq_select_pin_b(1'b0), .freq_select_pin_c(1'b0),
    .spi_mod(smod), .spi_pwr(spwr), .spi_dev(sdev), .spi_div(sdiv), .emulation_settings(es),
    .primary_cap(pc), .emu_active(act), .mod_fsk(fsk), .pwr_atten_db(atto), .dev_50k(dev),
    .div_ratio(dvo), .pa_cap(pa));
  emc_host emc_host_inst (.core_clk, .enable_pin(en), .din_pin(din));
  function automatic logic [22:0] ex(input logic [7:0] v, input logic man);
    ex = (v[7] && !man) ? {1'b1, v[6], att[v[5:4]], v[3], dv[v[2:0]]} :
      {1'b0, smod, att[spwr], sdev, sdiv};
  endfunction
  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    wp <= {wp[0], emu_wr & ce};
    if (wp[1]) chk("config", q.pop_front(), {act, fsk, atto, dev, dvo});
  end
  initial begin
    #20us;
    fail_count++;
    end_sim;
  end
  initial begin
    {smod, spwr, sdev} = 4'($random(seed));
    sdiv = 16'($random(seed));
    repeat (10) @(negedge core_clk);
    nrst = 1;
    for (int i = 0; i < 41; i++) begin
      @(negedge core_clk) emu_wr = 1;
      // Outputs of write i see the pin level driven one edge later
      fpa = (i >= 30 && i < 35);
      d = (i == 40) ? 8'h8b : 8'($random(seed));
      d[7] = (i % 5 != 0) || (i == 40);
      q.push_back(ex(d, i >= 29 && i < 34));
    end
    @(negedge core_clk) emu_wr = 0;
    repeat (3) @(negedge core_clk);
    $display("test config done");
    emc_host_inst.cap_pulses(7);
    repeat (3) @(negedge core_clk);
    chk("pulse cap", 23'h6, 23'(pa));
    @(negedge core_clk) cap_wr = 1;
    c = 5'h13;
    @(negedge core_clk) cap_wr = 0;
    emc_host_inst.cap_pulses(3);
    repeat (3) @(negedge core_clk);
    chk("written cap", 23'h13, 23'(pa));
    $display("test cap done");
    @(negedge core_clk) ce = 0;
    emu_wr = 1;
    cap_wr = 1;
    d = 8'($random(seed)) | 8'h40;
    c = 5'h04;
    @(negedge core_clk) ce = 1;
    emu_wr = 0;
    cap_wr = 0;
    @(negedge core_clk);
    chk("frozen settings", 23'h8b, 23'(es));
    chk("frozen cap", 23'h13, 23'(pc));
    $display("test freeze done");
    end_sim;
  end
endmodule // test_emulation_mode_config
`default_nettype wire

//--- verilog/cap_pulse_counter.v
`timescale 1ns/1ps
`default_nettype none
// Counts data-pin pulses while enable is low; first pulse clears and latches freq.
module cap_pulse_counter (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire enable_pin,
  input wire din_pin,
  input wire [2:0] freq_code,
  output reg [4:0] cap_q,
  output reg [2:0] cap_freq_q
);
  reg din_q;
  reg first_q;
  reg [4:0] cnt_q;
  reg [2:0] freq_pend_q;
  reg en_q;
  wire rise = din_pin & ~din_q;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      din_q <= 1'b0;
      first_q <= 1'b1;
      cnt_q <= 5'h00;
      freq_pend_q <= 3'h0;
      en_q <= 1'b1;
      cap_q <= 5'h00;
      cap_freq_q <= 3'h0;
    end else if (ce) begin
      din_q <= din_pin;
      en_q <= enable_pin;
      if (!enable_pin) begin
        if (en_q)
          first_q <= 1'b1;
        else if (rise) begin
          if (first_q) begin
            first_q <= 1'b0;
            cnt_q <= 5'h00;
            freq_pend_q <= freq_code;
          end else if (cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      end else if (!en_q && !first_q) begin
        // Count and frequency commit together, so the old pair stays whole while counting
        cap_q <= cnt_q;
        cap_freq_q <= freq_pend_q;
      end
    end
  end
endmodule // cap_pulse_counter
`default_nettype wire

//--- verilog/emulation_mode_config.v
`timescale 1ns/1ps
`default_nettype none
`include "emu_consts.vh"
module emulation_mode_config (
  input wire core_clk,
  input wire nrst,
  input wire ce,
  input wire emu_wr,
  input wire [7:0] emu_wdata,
  input wire cap_wr,
  input wire [4:0] cap_wdata,
  input wire enable_pin,
  input wire din_pin,
  input wire freq_select_pin_a,
  input wire freq_select_pin_b,
  input wire freq_select_pin_c,
  input wire spi_mod,
  input wire [1:0] spi_pwr,
  input wire spi_dev,
  input wire [15:0] spi_div,
  output wire [7:0] emulation_settings,
  output wire [4:0] primary_cap,
  output reg emu_active,
  output reg mod_fsk,
  output reg [3:0] pwr_atten_db,
  output reg dev_50k,
  output reg [15:0] div_ratio,
  output reg [4:0] pa_cap
);
  reg [7:0] emu_q;
  reg [4:0] capreg_q;
  wire [4:0] pulse_cap;
  wire [2:0] pulse_freq;
  // Emulation is an SPI-mode feature; any frequency pin high means manual mode
  wire spi_mode = ~(freq_select_pin_a | freq_select_pin_b | freq_select_pin_c);
  wire emu_on = emu_q[`EMU_EN_BIT] & spi_mode;
  wire [2:0] frq = emu_q[`EMU_FRQ_HI:`EMU_FRQ_LO];
  wire cap_written = (capreg_q != `CAP_RESET);
  wire pulse_hit = emu_on & (pulse_freq == frq) & (frq != 3'h0);
  reg mod_d;
  reg dev_d;
  reg [1:0] pwr;
  reg [3:0] att_d;
  reg [15:0] fixed_div;
  reg [15:0] div_d;
  reg [4:0] cap_d;

  // Emulation settings register
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      emu_q <= `EMU_RESET;
    end else if (ce) begin
      if (emu_wr) begin
        emu_q <= emu_wdata;
      end
    end
  end

  // Only the capacitor field of the primary config register lives here
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      capreg_q <= `CAP_RESET;
    end else if (ce) begin
      if (cap_wr) begin
        capreg_q <= cap_wdata;
      end
    end
  end

  // Pulse programming runs in any mode; its result is used only in emulation
  cap_pulse_counter u_pulse (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .enable_pin(enable_pin),
    .din_pin(din_pin),
    .freq_code(frq),
    .cap_q(pulse_cap),
    .cap_freq_q(pulse_freq)
  );

  // Each emulation bit stands in for one manual pin
  always @* begin
    if (emu_on) begin
      mod_d = emu_q[`EMU_MOD_BIT];
    end else begin
      mod_d = spi_mod;
    end
  end

  always @* begin
    if (emu_on) begin
      dev_d = emu_q[`EMU_DEV_BIT];
    end else begin
      dev_d = spi_dev;
    end
  end

  always @* begin
    if (emu_on) begin
      pwr = emu_q[`EMU_PWR_HI:`EMU_PWR_LO];
    end else begin
      pwr = spi_pwr;
    end
  end

  // Attenuation in dB below full power
  always @* begin
    case (pwr)
      2'b00: att_d = `PWR_ATT_0;
      2'b01: att_d = `PWR_ATT_1;
      2'b10: att_d = `PWR_ATT_2;
      2'b11: att_d = `PWR_ATT_3;
      default: att_d = `PWR_ATT_0;
    endcase
  end

  // Ratios are held to the nearest 1/256 step, a small fixed frequency error
  always @* begin
    case (frq)
      3'h1: fixed_div = `DIV_F1;
      3'h2: fixed_div = `DIV_F2;
      3'h3: fixed_div = `DIV_F3;
      3'h4: fixed_div = `DIV_F4;
      3'h5: fixed_div = `DIV_F5;
      3'h6: fixed_div = `DIV_F6;
      3'h7: fixed_div = `DIV_F7;
      default: fixed_div = `DIV_NONE;
    endcase
  end

  always @* begin
    if (emu_on) begin
      div_d = fixed_div;
    end else begin
      div_d = spi_div;
    end
  end

  // Pulse value applies only on the frequency it was latched for
  always @* begin
    if (cap_written) begin
      cap_d = capreg_q;
    end else if (pulse_hit) begin
      cap_d = pulse_cap;
    end else begin
      cap_d = `CAP_RESET;
    end
  end

  // Every setting leaves through a flop, so the analog side never sees a decode glitch
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      emu_active <= 1'b0;
    end else if (ce) begin
      emu_active <= emu_on;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mod_fsk <= `MOD_ASK;
    end else if (ce) begin
      mod_fsk <= mod_d;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_atten_db <= `PWR_ATT_0;
    end else if (ce) begin
      pwr_atten_db <= att_d;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dev_50k <= `DEV_16K;
    end else if (ce) begin
      dev_50k <= dev_d;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_ratio <= `DIV_NONE;
    end else if (ce) begin
      div_ratio <= div_d;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pa_cap <= `CAP_RESET;
    end else if (ce) begin
      pa_cap <= cap_d;
    end
  end

  assign emulation_settings = emu_q;
  assign primary_cap = capreg_q;
endmodule // emulation_mode_config
`default_nettype wire
